/* File: ahap_top.sv */
// pin-level front end of the asynchronous parallel host port
// expects host pins already synchronous to CORE_CLK and the host
// clock pin tied low on the board; data pins split into in/out/oe
//
// Functional notes
// - eight data pins carry write and read data
// - seven-bit address selects on-chip register
// - latch strobe high marks access start
// - address buffers open while latch strobe high
// - address latched on latch strobe falling edge
// - data-strobe style: address open while strobe low
// - read strobe low drives data, else float
// - write stored on rising write strobe edge

`timescale 1ns/1ps
`default_nettype none

module ahap_top
    import ahap_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic BUS_STYLE_SELECT_LOW,
    input wire logic BUS_STYLE_SELECT_HIGH,
    input wire logic HOST_CLK,
    input wire logic [6:0] ADDR,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic [7:0] DATA_OE,
    input wire logic CHIP_SELECT_N,
    input wire logic ADDRESS_LATCH_STROBE,
    input wire logic READ_OR_DATA_STROBE,
    input wire logic WRITE_OR_DIRECTION,
    output logic ADDR_BUF_EN,
    output logic DATA_IN_BUF_EN,
    output logic [6:0] LATCHED_ADDR,
    output logic ACCESS_START,
    output logic WRITE_STROBE,
    output logic [6:0] WRITE_ADDR,
    output logic [7:0] WRITE_DATA
);

    // ==========================================================
    // state of the whole port
    typedef struct packed {
        logic [6:0] addr_latch;
        logic [7:0] rd_data;
        logic drive;
        logic in_buf;
        logic addr_buf;
        logic start;
        logic [7:0] wdata_hold;
        ahap_wreq_t wreq;
        logic ds_write;
    } ahap_state_t;

    ahap_state_t state;
    ahap_state_t next_state;
    logic [7:0] regs [0:AHAP_REG_COUNT-1];

    // ==========================================================
    // bus style decode; the upper select is expected grounded
    // style is taken live each cycle, so a board must not move it mid-access
    ahap_style_t style;
    logic sel_high_unused;
    logic host_clk_unused;

    always_comb begin
        // upper select high has no defined style, fall back to low pin
        style = BUS_STYLE_SELECT_LOW ? AHAP_STYLE_DATASTROBE
                                     : AHAP_STYLE_SEPARATE;
    end

    assign sel_high_unused = BUS_STYLE_SELECT_HIGH;
    assign host_clk_unused = HOST_CLK;

    // ==========================================================
    // strobe qualification: read, write and data strobes count only with chip select
    // the latch strobe stays ungated, so an address still latches when
    // the host raises it before it lowers chip select
    logic cs;
    logic rd_n_q;
    logic wr_n_q;
    logic ds_n_q;
    logic ale_q;
    logic as_low;

    always_comb begin
        cs = ~CHIP_SELECT_N;
        ale_q = (style == AHAP_STYLE_SEPARATE) & ADDRESS_LATCH_STROBE;
        as_low = (style == AHAP_STYLE_DATASTROBE) & ~ADDRESS_LATCH_STROBE;
        rd_n_q = ~(cs & (style == AHAP_STYLE_SEPARATE) & ~READ_OR_DATA_STROBE);
        wr_n_q = ~(cs & (style == AHAP_STYLE_SEPARATE) & ~WRITE_OR_DIRECTION);
        ds_n_q = ~(cs & (style == AHAP_STYLE_DATASTROBE) & ~READ_OR_DATA_STROBE);
    end

    // ==========================================================
    // active-high strobe levels for the edge finders; the finders
    // reset to a low previous sample, so feeding them the idle-high
    // pins would fake a release, and a spurious write, right after reset
    logic wr_act;
    logic ds_act;

    assign wr_act = ~wr_n_q;
    assign ds_act = ~ds_n_q;

    // ==========================================================
    // edge finders for latch strobe, write strobe and data strobe;
    // each finder sees an active-high level, so the release of a
    // low-true pin is the fall of its level and the press its rise
    logic ale_rise;
    logic ale_fall;
    logic wr_rise;
    logic ds_rise;
    logic ds_fall;

    ahap_edge u_ale_edge (
        .clk(CORE_CLK),
        .rst_n(NRST),
        .level_in(ale_q),
        .rise(ale_rise),
        .fall(ale_fall)
    );

    // the pin rise of the write strobe is the commit edge
    ahap_edge u_wr_edge (
        .clk(CORE_CLK),
        .rst_n(NRST),
        .level_in(wr_act),
        .rise(),
        .fall(wr_rise)
    );

    // names keep the pin's sense: ds_fall is the strobe going low
    ahap_edge u_ds_edge (
        .clk(CORE_CLK),
        .rst_n(NRST),
        .level_in(ds_act),
        .rise(ds_fall),
        .fall(ds_rise)
    );

    // ==========================================================
    // next state of the port
    always_comb begin
        next_state = state;
        next_state.wreq.wr_en = 1'b0;
        next_state.start = ale_rise;
        // address buffers follow the style's strobe level
        next_state.addr_buf = ale_q | as_low;
        // separate style: capture on falling latch strobe
        if (ale_fall) begin
            next_state.addr_latch = ADDR;
        end else if (as_low) begin
            // data-strobe style tracks the pins while the strobe is low
            next_state.addr_latch = ADDR;
        end
        // input buffers open while the write strobe is low
        next_state.in_buf = ~wr_n_q | (~ds_n_q & ~WRITE_OR_DIRECTION);
        if (next_state.in_buf) begin
            next_state.wdata_hold = DATA_IN;
        end
        // write lands on the releasing edge of the write strobe
        if (wr_rise) begin
            next_state.wreq.wr_en = 1'b1;
            next_state.wreq.addr = state.addr_latch;
            next_state.wreq.wdata = state.wdata_hold;
        end
        // data-strobe style: direction sampled on strobe fall; the flag
        // is refreshed by every strobe press, so a stale write never
        // replays on a later read
        if (ds_fall) begin
            next_state.ds_write = ~WRITE_OR_DIRECTION;
        end
        if (ds_rise && state.ds_write) begin
            next_state.wreq.wr_en = 1'b1;
            next_state.wreq.addr = state.addr_latch;
            next_state.wreq.wdata = state.wdata_hold;
        end
        // read drive follows the read strobe low level, one core clock later
        next_state.drive = ~rd_n_q | (~ds_n_q & WRITE_OR_DIRECTION);
        // read data trails the latch by a cycle; a host must hold the
        // read strobe for at least two core clocks to see settled data
        next_state.rd_data = regs[state.addr_latch];
    end

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // target register array; storage only, no reset needed
    // reads of a never-written address return unknown contents
    always_ff @(posedge CORE_CLK) begin
        if (state.wreq.wr_en) begin
            regs[state.wreq.addr] <= state.wreq.wdata;
        end
    end

    // ==========================================================
    // outputs, all from flip-flops
    // the pad enable trails the strobe by one cycle, so the bus stays
    // driven for one core clock after the host lets go
    assign DATA_OUT = state.rd_data;
    assign DATA_OE = {AHAP_DATA_W{state.drive}};
    assign ADDR_BUF_EN = state.addr_buf;
    assign DATA_IN_BUF_EN = state.in_buf;
    assign LATCHED_ADDR = state.addr_latch;
    assign ACCESS_START = state.start;
    assign WRITE_STROBE = state.wreq.wr_en;
    assign WRITE_ADDR = state.wreq.addr;
    assign WRITE_DATA = state.wreq.wdata;

endmodule

`default_nettype wire

/* File: ahap_pkg.sv */
// package for the asynchronous host address port front end
// holds the bus style enumeration, pin bundle structs and widths
// assumes all host pins are sampled synchronously to CORE_CLK

package ahap_pkg;

    // ==========================================================
    // widths
    localparam int AHAP_ADDR_W = 7;
    localparam int AHAP_DATA_W = 8;
    localparam int AHAP_REG_COUNT = 128;

    // ==========================================================
    // reset values
    localparam logic [6:0] AHAP_ADDR_RESET = 7'h00;
    localparam logic [7:0] AHAP_DATA_RESET = 8'h00;
    localparam logic [7:0] AHAP_REG_RESET = 8'h00;

    // ==========================================================
    // bus style decoded from the low select pin only
    typedef enum logic {
        AHAP_STYLE_SEPARATE,
        AHAP_STYLE_DATASTROBE
    } ahap_style_t;

    // host side strobes, all taken as plain synchronous inputs
    typedef struct packed {
        logic chip_select_n;
        logic address_latch_strobe;
        logic read_or_data_strobe;
        logic write_or_direction;
    } ahap_strobes_t;

    // register file side request towards the core
    typedef struct packed {
        logic wr_en;
        logic [6:0] addr;
        logic [7:0] wdata;
    } ahap_wreq_t;

endpackage

/* File: ahap_edge.sv */
// edge and level helper for one host strobe
// assumes the input is already synchronous to the clock

`timescale 1ns/1ps
`default_nettype none

module ahap_edge
    import ahap_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic level_in,
    output logic rise,
    output logic fall
);

    // ==========================================================
    // previous sample
    typedef struct packed {
        logic prev;
    } ahap_edge_state_t;

    ahap_edge_state_t state;
    ahap_edge_state_t next_state;

    // keep the last sample to find transitions
    always_comb begin
        next_state = state;
        next_state.prev = level_in;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // idle-low reset means a strobe held high at release reads as a rise
    assign rise = level_in & ~state.prev;
    assign fall = ~level_in & state.prev;

endmodule

`default_nettype wire

/* File: ahap_checker.sv */
// assertions on the host port front end pins
// assumes the separate style idles with the latch strobe low
`timescale 1ns/1ps
`default_nettype none
module ahap_checker
    import ahap_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic BUS_STYLE_SELECT_LOW,
    input wire logic [6:0] ADDR,
    input wire logic [7:0] DATA_IN,
    input wire logic [7:0] DATA_OE,
    input wire logic CHIP_SELECT_N,
    input wire logic ADDRESS_LATCH_STROBE,
    input wire logic READ_OR_DATA_STROBE,
    input wire logic WRITE_OR_DIRECTION,
    input wire logic ADDR_BUF_EN,
    input wire logic DATA_IN_BUF_EN,
    input wire logic [6:0] LATCHED_ADDR,
    input wire logic ACCESS_START,
    input wire logic WRITE_STROBE,
    input wire logic [7:0] WRITE_DATA
);
    logic sep;
    logic als;
    logic rd;
    logic wr;
    // ====
    // strobes count only under chip select, the latch does not
    assign sep = !BUS_STYLE_SELECT_LOW;
    assign als = ADDRESS_LATCH_STROBE;
    assign rd = !CHIP_SELECT_N && !READ_OR_DATA_STROBE;
    assign wr = !CHIP_SELECT_N && !WRITE_OR_DIRECTION;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    property p_start; sep && $rose(als) |=> ACCESS_START ##1 !ACCESS_START; endproperty
    a_start: assert property (p_start) else $error("start");
    property p_abuf; sep |=> ADDR_BUF_EN == $past(als); endproperty
    a_abuf: assert property (p_abuf) else $error("abuf");
    property p_latch; sep && $fell(als) |=> LATCHED_ADDR == $past(ADDR); endproperty
    a_latch: assert property (p_latch) else $error("latch");
    property p_dsbuf; !sep |=> ADDR_BUF_EN == $past(!als); endproperty
    a_dsbuf: assert property (p_dsbuf) else $error("dsbuf");
    property p_rd; sep |=> DATA_OE == {8{$past(rd)}}; endproperty
    a_rd: assert property (p_rd) else $error("drive");
    property p_wbuf; sep |=> DATA_IN_BUF_EN == $past(wr); endproperty
    a_wbuf: assert property (p_wbuf) else $error("wbuf");
    property p_wr; sep && !CHIP_SELECT_N && $rose(WRITE_OR_DIRECTION)
        |=> WRITE_STROBE && WRITE_DATA == $past(DATA_IN, 2); endproperty
    a_wr: assert property (p_wr) else $error("commit");
    property p_cs; CHIP_SELECT_N |=> !WRITE_STROBE; endproperty
    a_cs: assert property (p_cs) else $error("unselected");
    cover property (sep && WRITE_STROBE);
    cover property (!sep && WRITE_STROBE);
    cover property ($rose(DATA_OE[0]));
endmodule
bind ahap_top ahap_checker u_chk (.*);
`default_nettype wire

/* File: ahap_host_model.sv */
// host processor model for the port pins
// assumes calls come from one bench process at a time
`timescale 1ns/1ps
`default_nettype none
module ahap_host_model
    import ahap_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic [7:0] DATA_OUT,
    input wire logic [7:0] DATA_OE,
    output logic [6:0] ADDR,
    output logic [7:0] DATA_IN,
    output logic CHIP_SELECT_N,
    output logic ADDRESS_LATCH_STROBE,
    output logic READ_OR_DATA_STROBE,
    output logic WRITE_OR_DIRECTION
);
    ahap_strobes_t p = 4'hB;
    logic [7:0] hd = 8'h00;
    // ====
    // a released wire shows the inverse of the last host value
    assign DATA_IN = DATA_OE[0] ? DATA_OUT : hd;
    assign {CHIP_SELECT_N, ADDRESS_LATCH_STROBE, READ_OR_DATA_STROBE, WRITE_OR_DIRECTION} = p;
    initial ADDR = 7'h00;
    // separate style; address moves after latching to prove the latch
    task automatic sep(input logic [6:0] a, input logic [7:0] d, input logic r,
                       input logic csn, output logic [7:0] q);
        @(posedge CORE_CLK) ADDR <= a;
        p.address_latch_strobe <= 1'b1;
        @(posedge CORE_CLK) p.address_latch_strobe <= 1'b0;
        @(posedge CORE_CLK) ADDR <= ~a;
        p <= {csn, 1'b0, !r, r};
        hd <= d;
        repeat (3) @(posedge CORE_CLK);
        q = DATA_OUT;
        p.write_or_direction <= 1'b1;
        @(posedge CORE_CLK) p <= 4'hB;
        @(posedge CORE_CLK) hd <= ~d;
    endtask
    // data-strobe style, address strobe low through the access
    task automatic dstr(input logic [6:0] a, input logic [7:0] d, input logic r,
                        output logic [7:0] q);
        @(posedge CORE_CLK) ADDR <= a;
        p <= {2'b00, 1'b1, r};
        hd <= d;
        @(posedge CORE_CLK) p.read_or_data_strobe <= 1'b0;
        repeat (3) @(posedge CORE_CLK);
        q = DATA_OUT;
        p.read_or_data_strobe <= 1'b1;
        @(posedge CORE_CLK) p <= 4'hF;
        @(posedge CORE_CLK) hd <= ~d;
    endtask
endmodule
`default_nettype wire

/* File: ahap_bench.sv */
// self-checking bench for the host port front end
// assumes the host model owns all strobes and the data wire
`timescale 1ns/1ps
`default_nettype none
module ahap_bench;
    logic CORE_CLK = 1'b0;
    logic NRST = 1'b0;
    logic BUS_STYLE_SELECT_LOW = 1'b0;
    logic BUS_STYLE_SELECT_HIGH = 1'b0;
    logic HOST_CLK = 1'b0;
    logic [6:0] ADDR, LATCHED_ADDR, WRITE_ADDR;
    logic [7:0] DATA_IN, DATA_OUT, DATA_OE, WRITE_DATA, q;
    logic CHIP_SELECT_N, ADDRESS_LATCH_STROBE, READ_OR_DATA_STROBE, WRITE_OR_DIRECTION;
    logic ADDR_BUF_EN, DATA_IN_BUF_EN, ACCESS_START, WRITE_STROBE;
    int bad_count = 0;
    int check_count = 0;
    logic [7:0] last_wr_addr = 8'h00;
    logic [7:0] last_wr_data = 8'h00;
    logic [7:0] wr_seen = 8'h00;
    // records every commit handed to the core, so stray strobes show up
    always @(posedge CORE_CLK) begin
        if (WRITE_STROBE === 1'b1) begin
            last_wr_addr <= {1'b0, WRITE_ADDR};
            last_wr_data <= WRITE_DATA;
            wr_seen <= wr_seen + 8'h01;
        end
    end
    // ====
    // 25 MHz core clock
    always #20 CORE_CLK = ~CORE_CLK;
    ahap_top u_dut (.*);
    ahap_host_model u_host (.*);
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // boundary addresses back to back, then an unselected write
    task automatic t_sep;
        u_host.sep(7'h00, 8'h5A, 1'b0, 1'b0, q);
        u_host.sep(7'h7F, 8'hA5, 1'b0, 1'b0, q);
        u_host.sep(7'h00, 8'h00, 1'b1, 1'b0, q);
        chk("rd00", 8'h5A, q);
        chk("waddr", 8'h7F, last_wr_addr);
        chk("wdata", 8'hA5, last_wr_data);
        u_host.sep(7'h7F, 8'hFF, 1'b0, 1'b1, q);
        u_host.sep(7'h7F, 8'h00, 1'b1, 1'b0, q);
        chk("rd7F", 8'hA5, q);
        chk("waddr_unsel", 8'h7F, last_wr_addr);
        chk("wdata_unsel", 8'hA5, last_wr_data);
        $display("sep test done");
    endtask
    // data-strobe write and read, then read back in separate style
    task automatic t_ds;
        @(posedge CORE_CLK) BUS_STYLE_SELECT_LOW <= 1'b1;
        u_host.p.address_latch_strobe <= 1'b1;
        u_host.dstr(7'h2A, 8'hC3, 1'b0, q);
        u_host.dstr(7'h2A, 8'h00, 1'b1, q);
        chk("ds", 8'hC3, q);
        chk("ds_waddr", 8'h2A, last_wr_addr);
        chk("ds_wdata", 8'hC3, last_wr_data);
        @(posedge CORE_CLK) BUS_STYLE_SELECT_LOW <= 1'b0;
        u_host.p.address_latch_strobe <= 1'b0;
        u_host.sep(7'h2A, 8'h00, 1'b1, 1'b0, q);
        chk("sep2A", 8'hC3, q);
        chk("wcount", 8'h03, wr_seen);
        $display("ds test done");
    endtask
    initial begin
        repeat (6) @(posedge CORE_CLK);
        NRST <= 1'b1;
        t_sep();
        t_ds();
        end_sim();
    end
    // cuts a hang short
    initial begin
        repeat (2000) @(posedge CORE_CLK);
        bad_count++;
        end_sim();
    end
endmodule
`default_nettype wire
